/* File: design/ppmcs_regs.sv */
// Power-management control/status and bridge extension register logic.
//
// Overview of operation
// - Wake events set status regardless of enable.
// - Writing one clears status; zero ignored.
// - Sticky flags across the main reset when cold-wake supported.
// - Wake output driven only while enabled.
// - Data scale read-only, zero without data.
// - Data select chooses data; zero without data.
// - Power state field encodes D0 to D3hot.
// - Unsupported state writes complete, data discarded.
// - Bridge extension byte reads all zeros.
//
// Configuration accesses arrive as a decoded dword strobe with byte
// enables for the dword that holds control/status, the bridge extension
// byte and the data byte. The block answers every access in the cycle it
// is taken; reads return data from a register one edge later.
`include "ppmcs_defs.svh"
module ppmcs_regs #(
  parameter logic DATA_REG_PRESENT = 1'b0,
  parameter logic COLD_WAKE_SUPPORT = 1'b1,
  parameter logic D1_SUPPORTED = 1'b1,
  parameter logic D2_SUPPORTED = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic aux_rst,
  input wire logic cfg_sel,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic [7:0] data_value,
  input wire logic wake_event,
  output logic pme_out,
  output logic pme_oe,
  output logic [1:0] power_state,
  output logic [3:0] data_select
);
  // =====================================================================
  // Declarations.
  ppmcs_evt_if evt_bus ();
  logic wr_lo;
  logic wr_hi;
  logic status_q;
  logic enable_q;
  logic clr_status;
  logic [1:0] ps_req;
  logic ps_ok;
  ppmcs_pkg::ppmcs_pstate_t ps_q;
  ppmcs_pkg::ppmcs_dsel_t dsel_q;
  logic [15:0] csr_view;
  logic [7:0] bse_view;
  logic [7:0] data_view;
  logic [1:0] scale_view;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic pme_q;

  // =====================================================================
  // Wake event enters from outside the clock domain.
  ppmcs_evt_sync u_sync (
    .clk (clk),
    .rst (rst),
    .evt_in (wake_event),
    .evt (evt_bus.src)
  );

  // =====================================================================
  // Write decode: byte lanes 0 and 1 hold the control/status register.
  assign wr_lo = cfg_sel & cfg_wr & cfg_be[0];
  assign wr_hi = cfg_sel & cfg_wr & cfg_be[1];

  // Status is cleared only by a one written to its bit.
  assign clr_status = wr_hi & cfg_wdata[`PPMCS_PME_STATUS_FLAG_BIT];

  // =====================================================================
  // Sticky status and enable flags.
  ppmcs_sticky u_sticky (
    .clk (clk),
    .rst (rst),
    .aux_rst (aux_rst),
    .sticky_en (COLD_WAKE_SUPPORT),
    .set_status (evt_bus.evt_pulse),
    .clr_status (clr_status),
    .wr_enable (wr_hi),
    .enable_d (cfg_wdata[`PPMCS_PME_ASSERT_ENABLE_BIT]),
    .status_q (status_q),
    .enable_q (enable_q)
  );

  // =====================================================================
  // Power state request check: optional states may be absent.
  assign ps_req = cfg_wdata[`PPMCS_PS_HI:`PPMCS_PS_LO];
  always_comb begin
    unique case (ps_req)
      2'h0: ps_ok = 1'b1;
      2'h1: ps_ok = D1_SUPPORTED;
      2'h2: ps_ok = D2_SUPPORTED;
      2'h3: ps_ok = 1'b1;
    endcase
  end

  // Power state register; unsupported requests leave it as it was.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ps_q <= ppmcs_pkg::PPMCS_D0;
    end else if (wr_lo && ps_ok) begin
      ps_q <= ppmcs_pkg::ppmcs_pstate_t'(ps_req);
    end
  end

  // Data select register exists only with a data register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dsel_q <= `PPMCS_DSEL_RESET;
    end else if (wr_hi && DATA_REG_PRESENT) begin
      dsel_q <= cfg_wdata[`PPMCS_DSEL_HI:`PPMCS_DSEL_LO];
    end
  end

  // =====================================================================
  // Read views; reserved bits and the bridge byte read zero.
  assign scale_view = `PPMCS_DS_VALUE;
  assign bse_view = `PPMCS_BSE_VALUE;
  assign data_view = DATA_REG_PRESENT ? data_value : 8'h00;
  assign csr_view = {status_q, scale_view, dsel_q, enable_q,
                     6'h00, ps_q};

  // Read data assembled per byte lane.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (cfg_sel && cfg_rd) begin
      rdata_d = {data_view, bse_view, csr_view};
    end
  end

  // Read data register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // =====================================================================
  // Wake output: driven low only while both status and enable are set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pme_q <= 1'b0;
    end else begin
      pme_q <= status_q & enable_q;
    end
  end

  // Open-drain pin: output level is always low, enable drives it.
  assign pme_out = 1'b0;
  assign pme_oe = pme_q;

  // Every access is accepted at once, including reserved-bit writes.
  assign cfg_ack = cfg_sel & (cfg_wr | cfg_rd);
  assign cfg_rdata = rdata_q;
  assign power_state = ps_q;
  assign data_select = dsel_q;
endmodule

/* File: inc/ppmcs_defs.svh */
// Offsets, field positions, reset values and defaults for PM control.
`ifndef PPMCS_DEFS_SVH
`define PPMCS_DEFS_SVH
// =====================================================================
// Register offsets within the capability (dword holding all three registers)
`define PPMCS_CAP_BASE 8'h34
`define PPMCS_CSR_OFS 8'h04
`define PPMCS_BSE_OFS 8'h06
`define PPMCS_DATA_OFS 8'h07
// =====================================================================
// Field positions of the control/status register
`define PPMCS_PME_STATUS_FLAG_BIT 15
`define PPMCS_DS_HI 14
`define PPMCS_DS_LO 13
`define PPMCS_DSEL_HI 12
`define PPMCS_DSEL_LO 9
`define PPMCS_PME_ASSERT_ENABLE_BIT 8
`define PPMCS_PS_HI 1
`define PPMCS_PS_LO 0
// =====================================================================
// Reset values and defaults
`define PPMCS_PS_RESET 2'h0
`define PPMCS_DSEL_RESET 4'h0
`define PPMCS_BSE_VALUE 8'h00
`define PPMCS_DS_VALUE 2'h0
`define PPMCS_SYNC_STAGES 2
`endif

/* File: inc/ppmcs_pkg.sv */
// Types shared by the power-management control/status logic.
package ppmcs_pkg;
  typedef enum logic [1:0] {
    PPMCS_D0 = 2'h0,
    PPMCS_D1 = 2'h1,
    PPMCS_D2 = 2'h2,
    PPMCS_D3HOT = 2'h3
  } ppmcs_pstate_t;
  typedef logic [3:0] ppmcs_dsel_t;
endpackage

/* File: inc/ppmcs_evt_if.sv */
// Carrier between the event synchroniser and the register logic.
interface ppmcs_evt_if;
  logic evt_pulse;
  modport src (output evt_pulse);
  modport dst (input evt_pulse);
endinterface

/* File: design/ppmcs_evt_sync.sv */
// Two-stage synchroniser and rising-edge detector for the wake event.
`include "ppmcs_defs.svh"
module ppmcs_evt_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic evt_in,
  ppmcs_evt_if.src evt
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  // =====================================================================
  // Synchroniser: the first stage feeds only the second.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= evt_in;
      sync_q <= meta_q;
    end
  end
  // Previous synchronised level for edge detection.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 1'b0;
    end else begin
      last_q <= sync_q;
    end
  end
  // One-cycle pulse on each rising edge of the event level.
  assign evt.evt_pulse = sync_q & ~last_q;
endmodule

/* File: design/ppmcs_sticky.sv */
// Sticky flag storage for wake status and enable, kept across the main reset when sticky_en is set.
module ppmcs_sticky (
  input wire logic clk,
  input wire logic rst,
  input wire logic aux_rst,
  input wire logic sticky_en,
  input wire logic set_status,
  input wire logic clr_status,
  input wire logic wr_enable,
  input wire logic enable_d,
  output logic status_q,
  output logic enable_q
);
  // =====================================================================
  // With sticky support only the auxiliary reset clears the flags.
  // Status flag: a set in the same cycle as a clear wins.
  always_ff @(posedge clk or posedge aux_rst) begin
    if (aux_rst) begin
      status_q <= 1'b0;
    end else if (rst && !sticky_en) begin
      status_q <= 1'b0;
    end else if (set_status) begin
      status_q <= 1'b1;
    end else if (clr_status) begin
      status_q <= 1'b0;
    end
  end
  // Enable flag written by configuration software.
  always_ff @(posedge clk or posedge aux_rst) begin
    if (aux_rst) begin
      enable_q <= 1'b0;
    end else if (rst && !sticky_en) begin
      enable_q <= 1'b0;
    end else if (wr_enable) begin
      enable_q <= enable_d;
    end
  end
endmodule

/* File: verif/ppmcs_regs_properties.sv */
// Checker for the power-management register port behaviour.
module ppmcs_regs_chk #(
  parameter logic D1_SUPPORTED = 1'b1,
  parameter logic D2_SUPPORTED = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_sel,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic pme_oe,
  input wire logic [1:0] power_state,
  input wire logic [3:0] data_select
);
  // ====================
  // Properties.
  logic unsup;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Flags a state write that names a state this function lacks.
  assign unsup = (cfg_wdata[1:0] == 2'h1 && !D1_SUPPORTED) ||
                 (cfg_wdata[1:0] == 2'h2 && !D2_SUPPORTED);
  sequence s_lo_wr;
    cfg_sel && cfg_wr && cfg_be[0];
  endsequence
  sequence s_hi_wr;
    cfg_sel && cfg_wr && cfg_be[1];
  endsequence
  property p_bse_zero;
    cfg_rdata[23:16] == 8'h00;
  endproperty
  property p_scale_zero;
    cfg_rdata[14:13] == 2'h0;
  endproperty
  property p_dsel_zero;
    data_select == 4'h0;
  endproperty
  property p_rsvd_zero;
    cfg_rdata[7:2] == 6'h00;
  endproperty
  property p_ps_take;
    s_lo_wr ##0 !unsup |=> power_state == $past(cfg_wdata[1:0]);
  endproperty
  property p_ps_drop;
    s_lo_wr ##0 unsup |=> $stable(power_state);
  endproperty
  property p_pme_clr;
    s_hi_wr ##0 cfg_wdata[15] |-> ##2 !pme_oe;
  endproperty
  property p_pme_dis;
    s_hi_wr ##0 !cfg_wdata[8] |-> ##2 (!pme_oe) [*2];
  endproperty
  a_bse_zero: assert property (p_bse_zero)
    else $error("bridge byte not zero");
  a_scale_zero: assert property (p_scale_zero)
    else $error("scale field not zero");
  a_dsel_zero: assert property (p_dsel_zero)
    else $error("data select not zero");
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits not zero");
  a_ps_take: assert property (p_ps_take)
    else $error("power state not taken");
  a_ps_drop: assert property (p_ps_drop)
    else $error("unsupported state taken");
  a_pme_clr: assert property (p_pme_clr)
    else $error("wake output not stopped");
  a_pme_dis: assert property (p_pme_dis)
    else $error("wake output while disabled");
endmodule
bind ppmcs_regs ppmcs_regs_chk #(
  .D1_SUPPORTED(D1_SUPPORTED),
  .D2_SUPPORTED(D2_SUPPORTED)
) u_chk (
  .clk(clk), .rst(rst), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
  .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .pme_oe(pme_oe), .power_state(power_state), .data_select(data_select)
);

/* File: verif/ppmcs_host_model.sv */
// Host bridge model that issues configuration accesses.
module ppmcs_host_model (
  input wire logic clk,
  output logic cfg_sel,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Access driver.
  // Bus starts idle.
  initial begin
    cfg_sel = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  // Holds one access across a rising edge, then releases the bus.
  task automatic acc(input logic w, input logic [3:0] be,
                     input logic [31:0] d);
    @(negedge clk);
    cfg_sel = 1'b1;
    cfg_wr = w;
    cfg_rd = !w;
    cfg_be = be;
    cfg_wdata = d & 32'hffffff03;
    @(negedge clk);
    cfg_sel = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = ~cfg_wdata;
  endtask
endmodule

/* File: verif/ppmcs_regs_tb_top.sv */
// Self-checking bench for the power-management register logic.
module ppmcs_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, aux_rst, wake_event, cfg_sel, cfg_wr, cfg_rd, cfg_ack;
  logic pme_out, pme_oe, st, en, rd_seen = 1'b0;
  logic [1:0] ps, power_state;
  logic [3:0] cfg_be, data_select;
  logic [7:0] data_value = 8'h00;
  logic [31:0] cfg_wdata, cfg_rdata, lfsr_q = 32'he2884423;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int total_checks = 0;
  // ====================
  // Instances, helpers and tests.
  ppmcs_regs #(.D2_SUPPORTED(1'b0)) dut (
    .clk(clk), .rst(rst), .aux_rst(aux_rst), .cfg_sel(cfg_sel),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .data_value(data_value), .wake_event(wake_event), .pme_out(pme_out),
    .pme_oe(pme_oe), .power_state(power_state), .data_select(data_select)
  );
  ppmcs_host_model host (
    .clk(clk), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd();
    exp_q.push_back({16'h0, st, 6'h0, en, 6'h0, ps});
    host.acc(1'b0, 4'hf, 32'h0);
  endtask
  task automatic wake();
    @(negedge clk);
    wake_event = 1'b1;
    repeat (2) @(negedge clk);
    wake_event = 1'b0;
    repeat (4) @(negedge clk);
    st = 1'b1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Random data byte and generator step.
  always @(negedge clk) begin
    lfsr_q <= lfsr(lfsr_q);
    data_value <= lfsr_q[7:0];
  end
  // Notes each read taken by the block.
  always @(posedge clk) begin
    rd_seen <= cfg_sel && cfg_rd && cfg_ack;
  end
  // Compares each read answer with the oldest note.
  always @(negedge clk) begin
    if (rd_seen) begin
      check("cfg_rdata", cfg_rdata, exp_q.pop_front());
    end
  end
  // Cuts a hang short.
  initial begin
    #50000;
    bad_count++;
    complete_run();
  end
  // Main sequence.
  initial begin
    {rst, aux_rst, wake_event, st, en, ps} = 7'h60;
    repeat (20) @(negedge clk);
    {rst, aux_rst} = 2'h0;
    rd();
    for (int s = 0; s < 4; s++) begin
      host.acc(1'b1, 4'h1, 32'(s));
      if (s != 2) ps = 2'(s);
      rd();
    end
    $display("state test done");
    wake();
    check("pme_oe", {31'h0, pme_oe}, 32'h0);
    rd();
    host.acc(1'b1, 4'he, (lfsr_q & 32'hffff7e00) | 32'h100);
    en = 1'b1;
    rd();
    check("pme_oe", {31'h0, pme_oe}, 32'h1);
    check("pme_out", {31'h0, pme_out}, 32'h0);
    check("data_select", {28'h0, data_select}, 32'h0);
    $display("wake test done");
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    ps = 2'h0;
    rd();
    host.acc(1'b1, 4'h2, 32'h8100);
    st = 1'b0;
    rd();
    check("pme_oe", {31'h0, pme_oe}, 32'h0);
    host.acc(1'b1, 4'h2, 32'h0);
    en = 1'b0;
    wake();
    check("pme_oe", {31'h0, pme_oe}, 32'h0);
    host.acc(1'b1, 4'h2, 32'h8000);
    st = 1'b0;
    rd();
    repeat (2) @(negedge clk);
    $display("sticky test done");
    complete_run();
  end
endmodule
